/* hdl/ialu_pkg.sv */
// Purpose: shared types and constants of the integer alu datapath
// Assumes: 32-bit data path, flags held inside the alu
// Notes:   opcode codes are internal and need not match any encoding
package ialu_pkg;

	localparam int unsigned IALU_W      = 32;
	localparam int unsigned IALU_SHW    = 8;
	localparam int unsigned IALU_CLZW   = 6;

	// masks applied to the program counter base and to branch targets
	localparam logic [31:0] IALU_PC_ALIGN_MASK = 32'hFFFF_FFFC;
	localparam logic [31:0] IALU_BRANCH_MASK   = 32'hFFFF_FFFE;
	localparam logic [11:0] IALU_TWELVE_BIT_IMMEDIATE_MAX     = 12'hFFF;
	localparam logic [19:0] IALU_TWELVE_BIT_IMMEDIATE_PAD     = 20'h0_0000;
	localparam logic [7:0]  IALU_SH_ZERO       = 8'h00;
	localparam logic [5:0]  IALU_CLZ_EMPTY     = 6'h20;

	typedef enum logic [4:0] {
		SUM_OP                       = 5'h00,
		SUM_WITH_CARRY_OP            = 5'h01,
		DIFFERENCE_OP                = 5'h02,
		DIFFERENCE_WITH_BORROW_OP    = 5'h03,
		REVERSED_DIFFERENCE_OP       = 5'h04,
		WIDE_IMMEDIATE_SUM_OP        = 5'h05,
		WIDE_IMMEDIATE_DIFFERENCE_OP = 5'h06,
		BITWISE_AND_OP               = 5'h07,
		BITWISE_DISJUNCTION_OP       = 5'h08,
		BITWISE_EXCLUSIVE_OP         = 5'h09,
		BIT_CLEAR_OP                 = 5'h0A,
		OR_COMPLEMENT_OP             = 5'h0B,
		SIGNED_RIGHT_SHIFT_OP        = 5'h0C,
		LEFT_SHIFT_OP                = 5'h0D,
		UNSIGNED_RIGHT_SHIFT_OP      = 5'h0E,
		RIGHT_ROTATE_OP              = 5'h0F,
		EXTENDED_ROTATE_OP           = 5'h10,
		LEADING_ZERO_COUNT_OP        = 5'h11
	} ialu_op_t;

	typedef struct packed {
		logic        n;
		logic        z;
		logic        c;
		logic        v;
	} ialu_flags_t;

	localparam ialu_flags_t IALU_FLAGS_RST = 4'h0;

	typedef struct packed {
		logic        valid;
		ialu_op_t    op;
		logic        set_flags;
		logic        use_imm;
		logic [11:0] twelve_bit_immediate;
		logic [31:0] first_src;
		logic        first_is_pc;
		logic        dest_is_pc;
		logic [31:0] flexible_second_operand;
		logic        op2_carry;
		logic        op2_carry_vld;
		logic [31:0] shift_src;
		logic        shift_by_reg;
		logic [5:0]  shift_imm;
		logic [31:0] shift_reg;
	} ialu_req_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] data;
		logic        pc_write;
		logic [31:0] pc_target;
	} ialu_res_t;

	localparam ialu_res_t IALU_RES_RST = '0;

endpackage : ialu_pkg

/* hdl/ialu_shifter.sv */
// Purpose: barrel shifter with carry out for shift and rotate ops
// Assumes: amount already reduced to its low byte by the caller
// Notes:   purely combinational; the caller registers the outputs
`timescale 1ns/1ns
`default_nettype none
module ialu_shifter
	import ialu_pkg::*;
(
	input  wire ialu_op_t    op_i,
	input  wire logic [31:0] value_i,
	input  wire logic [7:0]  amount_i,
	input  wire logic        carry_i,
	output var  logic [31:0] result_o,
	output var  logic        carry_o
);

	logic [32:0] left_w;
	logic [32:0] right_w;
	logic [32:0] arith_w;
	logic [31:0] rot_w;
	logic [5:0]  rot_back;

	// one extra bit beside the word catches the last bit shifted out
	always_comb begin
		left_w   = {1'b0, value_i} << amount_i;
		right_w  = {value_i, 1'b0} >> amount_i;
		arith_w  = 33'($signed({value_i, 1'b0}) >>> amount_i);
		rot_back = 6'h20 - {1'b0, amount_i[4:0]};
		rot_w    = (value_i >> amount_i[4:0]) | (value_i << rot_back);
		result_o = value_i;
		carry_o  = carry_i;
		unique case (op_i)
			LEFT_SHIFT_OP: begin
				if (amount_i != IALU_SH_ZERO) begin // RULE21
					{carry_o, result_o} = left_w;
				end
			end
			UNSIGNED_RIGHT_SHIFT_OP: begin
				if (amount_i != IALU_SH_ZERO) begin
					{result_o, carry_o} = right_w;
				end
			end
			SIGNED_RIGHT_SHIFT_OP: begin
				if (amount_i != IALU_SH_ZERO) begin
					{result_o, carry_o} = arith_w; // RULE25
				end
			end
			RIGHT_ROTATE_OP: begin
				// a rotate by 32 returns the word but still moves carry
				if (amount_i != IALU_SH_ZERO) begin
					result_o = rot_w;
					carry_o  = rot_w[31];
				end
			end
			EXTENDED_ROTATE_OP: begin
				result_o = {carry_i, value_i[31:1]}; // RULE19 RULE24
				carry_o  = value_i[0];
			end
			default: begin
			end
		endcase
	end

endmodule : ialu_shifter
`default_nettype wire

/* hdl/ialu_clz.sv */
// Purpose: leading zero counter for a 32-bit word
// Assumes: combinational use inside the alu
// Notes:   highest set bit is written last, so the highest set bit decides
`timescale 1ns/1ns
`default_nettype none
module ialu_clz
	import ialu_pkg::*;
(
	input  wire logic [31:0] value_i,
	output var  logic [5:0]  count_o
);

	// scan upward; each set bit overrides any lower one
	always_comb begin
		count_o = IALU_CLZ_EMPTY; // RULE22
		for (int i = 0; i < 32; i++) begin
			if (value_i[i]) begin
				count_o = 6'(31 - i);
			end
		end
	end

endmodule : ialu_clz
`default_nettype wire

/* hdl/ialu_core.sv */
// Purpose: integer execute stage: arithmetic, logic, shifts, clz
// Assumes: decoder supplies a resolved flexible operand and its carry
// Notes:   one request per cycle, result and flags one cycle later
//
// Overview of operation
// [RULE1] add writes first source plus flexible operand or 12-bit immediate
// [RULE2] the 12-bit immediate covers every value 0 through 4095
// [RULE3] add with carry adds first source, operand and carry flag
// [RULE4] subtract gives first source minus operand or immediate
// [RULE5] subtract with borrow takes one more when carry is clear
// [RULE6] reverse subtract gives operand minus first source
// [RULE7] wide immediate add and subtract match the immediate forms
// [RULE8] flags change only when flag setting is requested
// [RULE9] arithmetic with flag setting updates n, z, c and v
// [RULE10] program counter as source has its two low bits cleared
// [RULE11] add to program counter branches with bit 0 cleared
// [RULE12] stack pointer writes read it too, shift left at most 3
// [RULE13] program counter source: no flag setting, constant 0 to 4095
// [RULE14] and, exclusive or and or combine bit by bit
// [RULE15] bit clear ands, or-not ors, with operand complement
// [RULE16] logic flags: n and z from result, c from operand, v kept
// [RULE17] register shift amounts use only the low byte, 0 to 255
// [RULE18] immediate shifts: right 1-32, left 0-31, rotate 1-31
// [RULE19] extended rotate moves the word right by exactly one
// [RULE20] shifts write the destination only, source is untouched
// [RULE21] shift carry is the last bit out, kept for zero amount
// [RULE22] leading zero count is 32 for zero, 0 when bit 31 set
// [RULE23] leading zero count never touches the flags
// [RULE24] extended rotate puts old carry in bit 31, bit 0 to carry
// [RULE25] signed right shift copies the sign into vacated bits
`timescale 1ns/1ns
`default_nettype none
module ialu_core
	import ialu_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire ialu_req_t   req_i,
	output var  ialu_res_t   res_o,
	output var  ialu_flags_t flags_o
);

	ialu_res_t   res_r;
	ialu_res_t   res_nxt;
	ialu_flags_t flags_r;
	ialu_flags_t flags_nxt;

	logic [31:0] base_a;
	logic [31:0] opnd_b;
	logic [31:0] add_x;
	logic [31:0] add_y;
	logic        add_cin;
	logic [32:0] add_sum;
	logic        add_ovf;
	logic [31:0] logic_res;
	logic [7:0]  sh_amount;
	logic [31:0] sh_res;
	logic        sh_carry;
	logic [5:0]  clz_cnt;
	logic        is_arith;
	logic        is_logic;
	logic        is_shift;

	// shift source goes through a private copy, never written back
	ialu_shifter u_shifter (
		.op_i     (req_i.op),
		.value_i  (req_i.shift_src), // RULE20
		.amount_i (sh_amount),
		.carry_i  (flags_r.c),
		.result_o (sh_res),
		.carry_o  (sh_carry)
	);

	ialu_clz u_clz (
		.value_i (req_i.shift_src),
		.count_o (clz_cnt)
	);

	// register amounts keep only the low byte; immediates span 0..63
	always_comb begin
		sh_amount = {2'b00, req_i.shift_imm}; // RULE18
		if (req_i.shift_by_reg) begin
			sh_amount = req_i.shift_reg[7:0]; // RULE17
		end
	end

	// operand selection; the pc base is word aligned before use
	always_comb begin
		base_a = req_i.first_src;
		if (req_i.first_is_pc) begin
			base_a = req_i.first_src & IALU_PC_ALIGN_MASK; // RULE10
		end
		opnd_b = req_i.flexible_second_operand;
		if (req_i.use_imm
			|| req_i.op == WIDE_IMMEDIATE_SUM_OP
			|| req_i.op == WIDE_IMMEDIATE_DIFFERENCE_OP) begin
			opnd_b = {IALU_TWELVE_BIT_IMMEDIATE_PAD, req_i.twelve_bit_immediate}; // RULE2 RULE7
		end
	end

	// single adder; subtracts are x + ~y + carry-in
	always_comb begin
		add_x   = base_a;
		add_y   = opnd_b;
		add_cin = 1'b0;
		unique case (req_i.op)
			SUM_OP, WIDE_IMMEDIATE_SUM_OP: begin
				add_cin = 1'b0; // RULE1
			end
			SUM_WITH_CARRY_OP: begin
				add_cin = flags_r.c; // RULE3
			end
			DIFFERENCE_OP, WIDE_IMMEDIATE_DIFFERENCE_OP: begin
				add_y   = ~opnd_b; // RULE4
				add_cin = 1'b1;
			end
			DIFFERENCE_WITH_BORROW_OP: begin
				add_y   = ~opnd_b; // RULE5
				add_cin = flags_r.c;
			end
			REVERSED_DIFFERENCE_OP: begin
				add_x   = opnd_b; // RULE6
				add_y   = ~base_a;
				add_cin = 1'b1;
			end
			default: begin
			end
		endcase
		add_sum = {1'b0, add_x} + {1'b0, add_y} + {32'h0000_0000, add_cin};
		add_ovf = (add_x[31] == add_y[31]) && (add_sum[31] != add_x[31]);
	end

	// bitwise group; complement forms share the inverted operand
	always_comb begin
		logic_res = base_a & opnd_b;
		unique case (req_i.op)
			BITWISE_AND_OP:         logic_res = base_a & opnd_b; // RULE14
			BITWISE_DISJUNCTION_OP: logic_res = base_a | opnd_b;
			BITWISE_EXCLUSIVE_OP:   logic_res = base_a ^ opnd_b;
			BIT_CLEAR_OP:           logic_res = base_a & ~opnd_b; // RULE15
			OR_COMPLEMENT_OP:       logic_res = base_a | ~opnd_b;
			default: begin
			end
		endcase
	end

	// op class decode
	always_comb begin
		is_arith = (req_i.op inside {SUM_OP, SUM_WITH_CARRY_OP,
			DIFFERENCE_OP, DIFFERENCE_WITH_BORROW_OP,
			REVERSED_DIFFERENCE_OP, WIDE_IMMEDIATE_SUM_OP,
			WIDE_IMMEDIATE_DIFFERENCE_OP});
		is_logic = (req_i.op inside {BITWISE_AND_OP,
			BITWISE_DISJUNCTION_OP, BITWISE_EXCLUSIVE_OP,
			BIT_CLEAR_OP, OR_COMPLEMENT_OP});
		is_shift = (req_i.op inside {SIGNED_RIGHT_SHIFT_OP,
			LEFT_SHIFT_OP, UNSIGNED_RIGHT_SHIFT_OP,
			RIGHT_ROTATE_OP, EXTENDED_ROTATE_OP});
	end

	// next result and flags; flags hold unless a request asks to set
	always_comb begin
		res_nxt   = IALU_RES_RST;
		flags_nxt = flags_r; // RULE8
		if (req_i.valid) begin
			res_nxt.valid = 1'b1;
			if (is_arith) begin
				res_nxt.data = add_sum[31:0];
			end else if (is_logic) begin
				res_nxt.data = logic_res;
			end else if (is_shift) begin
				res_nxt.data = sh_res;
			end else begin
				res_nxt.data = {26'h0, clz_cnt}; // RULE22
			end
			// only the register add form may target the pc
			if (req_i.dest_is_pc && req_i.op == SUM_OP
				&& !req_i.use_imm) begin
				res_nxt.pc_write  = 1'b1;
				res_nxt.pc_target = add_sum[31:0] & IALU_BRANCH_MASK; // RULE11
			end
			// decoder keeps flag setting off for pc sources
			if (req_i.set_flags) begin // RULE13
				if (is_arith) begin
					flags_nxt.n = add_sum[31]; // RULE9
					flags_nxt.z = (add_sum[31:0] == 32'h0000_0000);
					flags_nxt.c = add_sum[32];
					flags_nxt.v = add_ovf;
				end else if (is_logic) begin
					flags_nxt.n = logic_res[31]; // RULE16
					flags_nxt.z = (logic_res == 32'h0000_0000);
					if (req_i.op2_carry_vld) begin
						flags_nxt.c = req_i.op2_carry;
					end
				end else if (is_shift) begin
					flags_nxt.n = sh_res[31]; // RULE21
					flags_nxt.z = (sh_res == 32'h0000_0000);
					flags_nxt.c = sh_carry; // RULE24
				end
				// leading zero count falls through, flags kept
			end
		end
	end

	// registers only
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			res_r   <= IALU_RES_RST;
			flags_r <= IALU_FLAGS_RST;
		end else begin
			res_r   <= res_nxt;
			flags_r <= flags_nxt;
		end
	end

	assign res_o   = res_r;
	assign flags_o = flags_r;

	// checks on the registered outputs against the sampled request
	property p_flags_hold;
		@(posedge clk_i) disable iff (sys_rst_i)
		!(req_i.valid && req_i.set_flags) |=> $stable(flags_o);
	endproperty
	a_flags_hold: assert property (p_flags_hold) // RULE8
		else $error("flags changed without a flag-setting request");

	property p_add_reg;
		@(posedge clk_i) disable iff (sys_rst_i)
		req_i.valid && req_i.op == SUM_OP && !req_i.use_imm
			&& !req_i.first_is_pc
		|=> res_o.valid
			&& res_o.data == $past(req_i.first_src) + $past(req_i.flexible_second_operand);
	endproperty
	a_add_reg: assert property (p_add_reg) // RULE1
		else $error("register add result wrong");

	property p_wide_sum;
		@(posedge clk_i) disable iff (sys_rst_i)
		req_i.valid && req_i.op == WIDE_IMMEDIATE_SUM_OP
			&& !req_i.first_is_pc
		|=> res_o.data == $past(req_i.first_src)
			+ {IALU_TWELVE_BIT_IMMEDIATE_PAD, $past(req_i.twelve_bit_immediate)};
	endproperty
	a_wide_sum: assert property (p_wide_sum) // RULE7
		else $error("wide immediate add differs from immediate add");

	property p_adc;
		@(posedge clk_i) disable iff (sys_rst_i)
		req_i.valid && req_i.op == SUM_WITH_CARRY_OP && !req_i.use_imm
			&& !req_i.first_is_pc
		|=> res_o.data == $past(req_i.first_src) + $past(req_i.flexible_second_operand)
			+ {31'h0, $past(flags_o.c)};
	endproperty
	a_adc: assert property (p_adc) // RULE3
		else $error("add with carry result wrong");

	property p_sbc;
		@(posedge clk_i) disable iff (sys_rst_i)
		req_i.valid && req_i.op == DIFFERENCE_WITH_BORROW_OP
			&& !req_i.use_imm && !req_i.first_is_pc
		|=> res_o.data == $past(req_i.first_src) - $past(req_i.flexible_second_operand)
			- {31'h0, !$past(flags_o.c)};
	endproperty
	a_sbc: assert property (p_sbc) // RULE5
		else $error("subtract with borrow result wrong");

	property p_rsb;
		@(posedge clk_i) disable iff (sys_rst_i)
		req_i.valid && req_i.op == REVERSED_DIFFERENCE_OP
			&& !req_i.use_imm && !req_i.first_is_pc
		|=> res_o.data == $past(req_i.flexible_second_operand) - $past(req_i.first_src);
	endproperty
	a_rsb: assert property (p_rsb) // RULE6
		else $error("reverse subtract result wrong");

	property p_pc_base;
		@(posedge clk_i) disable iff (sys_rst_i)
		req_i.valid && req_i.first_is_pc && req_i.use_imm
			&& req_i.op == DIFFERENCE_OP
		|=> res_o.data == ($past(req_i.first_src) & IALU_PC_ALIGN_MASK)
			- {IALU_TWELVE_BIT_IMMEDIATE_PAD, $past(req_i.twelve_bit_immediate)};
	endproperty
	a_pc_base: assert property (p_pc_base) // RULE10
		else $error("pc base not word aligned");

	property p_branch;
		@(posedge clk_i) disable iff (sys_rst_i)
		req_i.valid && req_i.dest_is_pc && req_i.op == SUM_OP
			&& !req_i.use_imm
		|=> res_o.pc_write && !res_o.pc_target[0]
			&& res_o.pc_target[31:1] == res_o.data[31:1];
	endproperty
	a_branch: assert property (p_branch) // RULE11
		else $error("pc write target not cleared in bit 0");

	property p_clz_flags;
		@(posedge clk_i) disable iff (sys_rst_i)
		req_i.valid && req_i.op == LEADING_ZERO_COUNT_OP
		|=> $stable(flags_o) && res_o.data <= 32'h0000_0020;
	endproperty
	a_clz_flags: assert property (p_clz_flags) // RULE23
		else $error("leading zero count touched flags");

	property p_logic_v;
		@(posedge clk_i) disable iff (sys_rst_i)
		req_i.valid && req_i.set_flags && is_logic
		|=> flags_o.v == $past(flags_o.v)
			&& flags_o.z == (res_o.data == 32'h0000_0000);
	endproperty
	a_logic_v: assert property (p_logic_v) // RULE16
		else $error("logic op changed overflow or zero wrong");

	property p_shift_zero;
		@(posedge clk_i) disable iff (sys_rst_i)
		req_i.valid && req_i.set_flags && sh_amount == IALU_SH_ZERO
			&& is_shift && req_i.op != EXTENDED_ROTATE_OP
		|=> flags_o.c == $past(flags_o.c)
			&& res_o.data == $past(req_i.shift_src);
	endproperty
	a_shift_zero: assert property (p_shift_zero) // RULE21
		else $error("zero shift altered carry or data");

	property p_rrx;
		@(posedge clk_i) disable iff (sys_rst_i)
		req_i.valid && req_i.set_flags && req_i.op == EXTENDED_ROTATE_OP
		|=> res_o.data == {$past(flags_o.c), $past(req_i.shift_src[31:1])}
			&& flags_o.c == $past(req_i.shift_src[0]);
	endproperty
	a_rrx: assert property (p_rrx) // RULE24
		else $error("extended rotate wrong");

	property p_asr_sign;
		@(posedge clk_i) disable iff (sys_rst_i)
		req_i.valid && req_i.op == SIGNED_RIGHT_SHIFT_OP
			&& sh_amount != IALU_SH_ZERO
		|=> res_o.data[31] == $past(req_i.shift_src[31]);
	endproperty
	a_asr_sign: assert property (p_asr_sign) // RULE25
		else $error("signed shift lost the sign");

endmodule : ialu_core
`default_nettype wire

/* testbench/ialu_decode_model.sv */
// Purpose: decode stage model that hands requests to the alu
// Assumes: bench gives one legal request per cycle on cmd_i
// Notes:   idle cycles scramble every field but valid so stale operands show up
`timescale 1ns/1ns
`default_nettype none
module ialu_decode_model
	import ialu_pkg::*;
(
	input  wire logic      clk_i,
	input  wire logic      sys_rst_i,
	input  wire ialu_req_t cmd_i,
	output var  ialu_req_t req_o
);
	// one register stage like a real decoder; no valid means the fields
	// are released, so they flip every cycle instead of holding
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			req_o <= '0;
		end else if (cmd_i.valid) begin
			req_o <= cmd_i;
		end else begin
			req_o <= ialu_req_t'({1'b0, ~req_o[$bits(ialu_req_t)-2:0]});
		end
	end
endmodule : ialu_decode_model
`default_nettype wire

/* testbench/test_integer_alu_shift_clz.sv */
// Purpose: self-checking bench of the integer alu datapath
// Assumes: result and flags appear one cycle after the request is taken
// Notes:   expectations come from a bench model with its own flag copy
`timescale 1ns/1ns
`default_nettype none
module test_integer_alu_shift_clz
	import ialu_pkg::*;
;
	typedef struct packed {
		logic [31:0] d;
		ialu_flags_t f;
		logic        pw;
		logic [31:0] pt;
	} ialu_exp_t;
	logic        clk_i;
	logic        sys_rst_i;
	ialu_req_t   cmd;
	ialu_req_t   req;
	ialu_res_t   res_o;
	ialu_flags_t flags_o;
	ialu_flags_t mf;
	ialu_exp_t   notes[$];
	int          errors;
	int          checks_done;
	int          cycles;
	ialu_op_t    lg[5] = '{BITWISE_AND_OP, BITWISE_DISJUNCTION_OP,
		BITWISE_EXCLUSIVE_OP, BIT_CLEAR_OP, OR_COMPLEMENT_OP};
	ialu_op_t    sh[4] = '{SIGNED_RIGHT_SHIFT_OP, LEFT_SHIFT_OP,
		UNSIGNED_RIGHT_SHIFT_OP, RIGHT_ROTATE_OP};
	logic [31:0] amt[7] = '{32'h0, 32'h1, 32'h1F, 32'h20, 32'h21,
		32'hFFFF_FF00, 32'h1FF};
	// immediate forms: wide ones at both ends, plain ones at the top
	ialu_op_t    im[6] = '{WIDE_IMMEDIATE_SUM_OP,
		WIDE_IMMEDIATE_DIFFERENCE_OP, SUM_OP, DIFFERENCE_OP,
		WIDE_IMMEDIATE_SUM_OP, WIDE_IMMEDIATE_DIFFERENCE_OP};

	ialu_decode_model ialu_decode_model_inst (.clk_i(clk_i),
		.sys_rst_i(sys_rst_i), .cmd_i(cmd), .req_o(req));
	ialu_core ialu_core_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.req_i(req), .res_o(res_o), .flags_o(flags_o));

	// free running clock, 8 ns period
	initial clk_i = 1'b0;
	always #4 clk_i = ~clk_i;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic final_report();
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : final_report

	// bench reference of one request; f is the flag state before it
	function automatic ialu_exp_t model(ialu_req_t r, ialu_flags_t f);
		logic [31:0] a, b, x, y, d, v;
		logic [32:0] s;
		logic [63:0] t;
		logic [7:0]  n;
		logic        c, ov, ci;
		ialu_exp_t   e;
		a = r.first_is_pc ? (r.first_src & IALU_PC_ALIGN_MASK) : r.first_src;
		b = r.use_imm ? {IALU_TWELVE_BIT_IMMEDIATE_PAD, r.twelve_bit_immediate} : r.flexible_second_operand;
		n = r.shift_by_reg ? r.shift_reg[7:0] : {2'h0, r.shift_imm};
		v = r.shift_src;
		{c, ov, x, y, ci} = {f.c, f.v, a, b, 1'b0};
		case (r.op)
			SUM_WITH_CARRY_OP: ci = f.c;
			DIFFERENCE_OP, WIDE_IMMEDIATE_DIFFERENCE_OP: {y, ci} = {~b, 1'b1};
			DIFFERENCE_WITH_BORROW_OP: {y, ci} = {~b, f.c};
			REVERSED_DIFFERENCE_OP: {x, y, ci} = {b, ~a, 1'b1};
			default: ;
		endcase
		s = {1'b0, x} + {1'b0, y} + {32'h0, ci};
		d = s[31:0];
		if (r.op <= WIDE_IMMEDIATE_DIFFERENCE_OP) begin
			c = s[32];
			ov = (x[31] == y[31]) && (d[31] != x[31]);
		end
		if (r.op >= BITWISE_AND_OP && r.op <= OR_COMPLEMENT_OP) begin
			c = r.op2_carry_vld ? r.op2_carry : f.c;
		end
		// 64-bit windows give the carry as the bit just past the word
		case (r.op)
			BITWISE_AND_OP: d = a & b;
			BITWISE_DISJUNCTION_OP: d = a | b;
			BITWISE_EXCLUSIVE_OP: d = a ^ b;
			BIT_CLEAR_OP: d = a & ~b;
			OR_COMPLEMENT_OP: d = a | ~b;
			LEFT_SHIFT_OP: begin
				t = {32'h0, v} << n;
				{d, c} = {t[31:0], t[32]};
			end
			UNSIGNED_RIGHT_SHIFT_OP: begin
				t = {v, 32'h0} >> n;
				{d, c} = {t[63:32], t[31]};
			end
			SIGNED_RIGHT_SHIFT_OP: begin
				t = $signed({v, 32'h0}) >>> n;
				{d, c} = {t[63:32], t[31]};
			end
			RIGHT_ROTATE_OP: begin
				// a doubled word slid right gives the rotation directly
				t = {v, v} >> n[4:0];
				d = t[31:0];
				c = d[31];
			end
			EXTENDED_ROTATE_OP: {d, c} = {f.c, v};
			LEADING_ZERO_COUNT_OP: begin
				d = 32'h20;
				for (int i = 0; i < 32; i++) if (v[i]) d = 32'(31 - i);
			end
			default: ;
		endcase
		if (r.op >= SIGNED_RIGHT_SHIFT_OP && r.op <= RIGHT_ROTATE_OP && n == 0)
			c = f.c;
		e.d = d;
		e.f = f;
		if (r.set_flags && r.op != LEADING_ZERO_COUNT_OP) e.f = {d[31], d == 0, c, ov};
		e.pw = r.op == SUM_OP && !r.use_imm && r.dest_is_pc;
		e.pt = e.pw ? (d & IALU_BRANCH_MASK) : 32'h0;
		return e;
	endfunction : model

	function automatic ialu_req_t mk(ialu_op_t op, logic sf, logic [31:0] a, b);
		ialu_req_t r;
		r = '0;
		{r.op, r.set_flags, r.first_src, r.flexible_second_operand} = {op, sf, a, b};
		{r.shift_src, r.shift_reg, r.shift_by_reg} = {a, b, 1'b1};
		return r;
	endfunction : mk

	// legalise as the decoder would, note the expectation, drive one cycle
	task automatic send(input ialu_req_t r);
		ialu_exp_t e;
		if (!(r.op inside {SUM_OP, DIFFERENCE_OP, WIDE_IMMEDIATE_SUM_OP,
			WIDE_IMMEDIATE_DIFFERENCE_OP})) {r.first_is_pc, r.use_imm} = 2'h0;
		if (r.op inside {WIDE_IMMEDIATE_SUM_OP, WIDE_IMMEDIATE_DIFFERENCE_OP})
			r.use_imm = 1'b1;
		if (r.op == SUM_OP && !r.use_imm && r.dest_is_pc) begin
			{r.set_flags, r.first_is_pc} = 2'h1;
		end else if (r.first_is_pc) begin
			{r.set_flags, r.use_imm} = 2'h1;
		end
		r.valid = 1'b1;
		e = model(r, mf);
		mf = e.f;
		notes.push_back(e);
		cmd <= r;
		@(posedge clk_i);
	endtask : send

	task automatic idle();
		cmd.valid <= 1'b0;
		@(posedge clk_i);
	endtask : idle

	// results are taken at the falling edge, settled since the rising one
	always @(negedge clk_i) begin
		if (!sys_rst_i && res_o.valid === 1'b1) begin
			if (notes.size() == 0) begin
				check(32'h1, 32'h0);
			end else begin
				ialu_exp_t e;
				e = notes.pop_front();
				check(res_o.data, e.d);
				check({28'h0, flags_o}, {28'h0, e.f});
				check({31'h0, res_o.pc_write}, {31'h0, e.pw});
				check(res_o.pc_target, e.pt);
			end
		end
	end

	// hang guard, well above the under one thousand cycles the run needs
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			final_report();
		end
	end

	initial begin
		ialu_req_t r;
		mf = IALU_FLAGS_RST;
		cmd <= '0;
		sys_rst_i <= 1'b1;
		void'($urandom(32'h9A00));
		repeat (4) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		// arithmetic, immediates at both ends, carry chains, overflow
		send(mk(SUM_OP, 1'b1, 32'h5, 32'h7));
		for (int k = 0; k < 6; k++) begin
			r = mk(im[k], 1'b1, 32'h10, 32'h0);
			{r.use_imm, r.twelve_bit_immediate} = {1'b1, k < 2 ? 12'h0 : IALU_TWELVE_BIT_IMMEDIATE_MAX};
			send(r);
		end
		send(mk(SUM_OP, 1'b1, 32'hFFFF_FFFF, 32'h1));
		send(mk(SUM_WITH_CARRY_OP, 1'b1, 32'h0, 32'h0));
		send(mk(DIFFERENCE_WITH_BORROW_OP, 1'b1, 32'h5, 32'h5));
		send(mk(DIFFERENCE_WITH_BORROW_OP, 1'b1, 32'h5, 32'h5));
		send(mk(SUM_OP, 1'b1, 32'h7FFF_FFFF, 32'h1));
		send(mk(REVERSED_DIFFERENCE_OP, 1'b0, 32'h3, 32'h500));
		$display("test arithmetic finished");
		// program counter base and branch through the add form
		r = mk(DIFFERENCE_OP, 1'b1, 32'h1003, 32'h0);
		{r.first_is_pc, r.use_imm, r.twelve_bit_immediate} = {2'h3, 12'h4};
		send(r);
		r = mk(SUM_OP, 1'b0, 32'h2002, 32'h101);
		r.dest_is_pc = 1'b1;
		send(r);
		r.op = DIFFERENCE_OP;
		send(r);
		$display("test program counter finished");
		// logic group with and without operand carry
		foreach (lg[i]) begin
			r = mk(lg[i], 1'b1, 32'hF0F0_1234, 32'hFF00_00FF);
			{r.op2_carry, r.op2_carry_vld} = 2'(i);
			send(r);
		end
		$display("test logic finished");
		// shifts over register amounts, then immediate amounts, then rrx
		send(mk(SUM_OP, 1'b1, 32'hFFFF_FFFF, 32'h1));
		foreach (sh[i]) foreach (amt[j]) send(mk(sh[i], 1'b1, 32'h8000_0001, amt[j]));
		foreach (sh[i]) for (int k = 0; k < 3; k++) begin
			r = mk(sh[i], 1'b1, 32'hC000_0003, 32'h0);
			{r.shift_by_reg, r.shift_imm} = {1'b0, 6'(k == 0 ? 1 : 30 + k)};
			send(r);
		end
		for (int k = 0; k < 4; k++) send(mk(EXTENDED_ROTATE_OP, 1'(k), 32'h3 >> k, 0));
		$display("test shifts finished");
		// leading zeros with flag setting asked for, which must not act
		foreach (amt[j]) send(mk(LEADING_ZERO_COUNT_OP, 1'b1, amt[j] << j, 0));
		send(mk(LEADING_ZERO_COUNT_OP, 1'b1, 32'h8000_0000, 0));
		$display("test leading zeros finished");
		// random traffic with idle gaps that scramble the released fields
		for (int k = 0; k < 600; k++) begin
			if ($urandom_range(3, 0) == 0) idle();
			r = mk(ialu_op_t'(5'($urandom_range(17, 0))), 1'($urandom), $urandom, $urandom);
			{r.use_imm, r.twelve_bit_immediate, r.dest_is_pc} = 14'($urandom);
			{r.op2_carry, r.op2_carry_vld, r.shift_by_reg} = 3'($urandom);
			{r.shift_imm, r.first_is_pc} = {6'($urandom_range(32, 0)), 1'($urandom_range(7, 0) == 0)};
			send(r);
		end
		idle();
		for (int k = 0; k < 50 && notes.size() != 0; k++) @(posedge clk_i);
		check(32'(notes.size()), 32'h0);
		$display("test random finished");
		final_report();
	end
endmodule : test_integer_alu_shift_clz
`default_nettype wire
